// File: srl_pkg.sv
// Shared constants of the SDI-12 recorder link.
`default_nettype none
package srl_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int BAUD = 1200;
  localparam int BIT_CYCLES = (CLK_HZ + BAUD / 2) / BAUD;
  localparam int BREAK_MS = 12;
  localparam int BREAK_CYCLES = BREAK_MS * (CLK_HZ / 1000);
  localparam int MARK_US = 8330;
  localparam int MARK_CYCLES = MARK_US * (CLK_HZ / 1_000_000);
  // Allows for the sensor's lead-in and one character.
  localparam int RESP_TIMEOUT_MS = 25;
  localparam int RESP_CYCLES = RESP_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int SEC_CYCLES = CLK_HZ;
  localparam logic [7:0] PROTO_REV = 8'h14;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_OP_TX = 8'h10;
  localparam logic [7:0] ADDR_OP_RX = 8'h14;
  localparam logic [7:0] ADDR_PORTCFG = 8'h18;
  localparam logic [7:0] ADDR_RESP_BASE = 8'h20;
  localparam logic [7:0] ADDR_RESP_LAST = 8'h5c;
  // Field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_PASS = 1;
  localparam int CTRL_QUERY = 2;
  localparam int CTRL_ADDR_LSB = 8;
  localparam int CTRL_RETRY_LSB = 16;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_RX = 2;
  localparam int CFG_ENABLE = 0;
  localparam int CFG_ON_TWO = 1;
  // Reset values
  localparam logic [6:0] RST_ADDR = 7'h30;
  localparam logic [3:0] RST_RETRY = 4'h3;
  localparam logic [1:0] RST_PORTCFG = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // Characters
  // ----------------------------------------------------------------
  localparam logic [6:0] CH_ZERO = 7'h30;
  localparam logic [6:0] CH_NINE = 7'h39;
  localparam logic [6:0] CH_LA = 7'h61;
  localparam logic [6:0] CH_LZ = 7'h7a;
  localparam logic [6:0] CH_UA = 7'h41;
  localparam logic [6:0] CH_UZ = 7'h5a;
  localparam logic [6:0] CH_QM = 7'h3f;
  localparam logic [6:0] CH_EXCL = 7'h21;
  localparam logic [6:0] CH_M = 7'h4d;
  localparam logic [6:0] CH_D = 7'h44;
  localparam logic [6:0] CH_CR = 7'h0d;
  localparam logic [6:0] CH_LF = 7'h0a;
endpackage : srl_pkg
`default_nettype wire

// File: srl_recorder_link.sv
// Recorder end of an SDI-12 sensor link with an AXI4-Lite register slave.
// How it works
// [RULE1] Link runs at fixed 1200 baud.
// [RULE2] Commands and answers follow revision 1.4.
// [RULE3] Address character always goes out first.
// [RULE4] Addresses are 0-9, a-z, A-Z only.
// [RULE5] Question mark addresses any sensor in query.
// [RULE6] Body is upper-case letter plus qualifiers.
// [RULE7] Every command ends with exclamation mark.
// [RULE8] Sensor answers end with CR then LF.
// [RULE9] Measure, wait reported seconds, then request data.
// [RULE10] Bad or missing answer resends automatically.
// [RULE11] Operator characters wait for sequencer idle.
// [RULE12] Link terminal blocks partner's counting functions.
// [RULE13] Retries exhausted flags failure, result invalid.
//
// Added by the designer: the address map and register access over AXI4-Lite.
`default_nettype none
module srl_recorder_link #(
  parameter int BIT_CYCLES = srl_pkg::BIT_CYCLES,
  parameter int BREAK_CYCLES = srl_pkg::BREAK_CYCLES,
  parameter int MARK_CYCLES = srl_pkg::MARK_CYCLES,
  parameter int RESP_CYCLES = srl_pkg::RESP_CYCLES,
  parameter int SEC_CYCLES = srl_pkg::SEC_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // SDI-12 data wire
  input wire logic sdiIn,
  output logic sdiOut,
  output logic sdiOe,
  // Interrupt and terminal-pair availability
  output logic irq,
  output logic controlTerminalOneCountFree,
  output logic controlTerminalTwoCountFree
);
  typedef enum logic [2:0] {SQ_IDLE, SQ_BREAK, SQ_SEND, SQ_WAIT, SQ_MEAS} srl_seq_e;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic srl_addr_ok(input logic [6:0] c);
    return (c >= srl_pkg::CH_ZERO && c <= srl_pkg::CH_NINE) ||
           (c >= srl_pkg::CH_LA && c <= srl_pkg::CH_LZ) ||
           (c >= srl_pkg::CH_UA && c <= srl_pkg::CH_UZ); // [RULE4]
  endfunction : srl_addr_ok

  function automatic logic [9:0] srl_digit(input logic [6:0] c);
    logic [6:0] d;
    d = c - srl_pkg::CH_ZERO;
    return (c >= srl_pkg::CH_ZERO && c <= srl_pkg::CH_NINE) ? {3'b000, d} : 10'd0;
  endfunction : srl_digit

  // Only M, D0 and the query are built.
  function automatic logic [6:0] srl_cmd_char(input logic q, input logic d,
                                              input logic [6:0] a, input logic [1:0] i);
    logic [6:0] c;
    c = srl_pkg::CH_EXCL; // [RULE7]
    if (i == 2'd0) begin
      c = q ? srl_pkg::CH_QM : a; // [RULE3] [RULE5]
    end else if (!q && i == 2'd1) begin
      c = d ? srl_pkg::CH_D : srl_pkg::CH_M; // [RULE6]
    end else if (!q && d && i == 2'd2) begin
      c = srl_pkg::CH_ZERO;
    end
    return c;
  endfunction : srl_cmd_char

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  srl_seq_e state;
  logic ctrlPass, ctrlQuery, linkEnable, linkOnTwo;
  logic [6:0] ctrlAddr;
  logic [3:0] ctrlMaxRetry, retryCnt, respIdx;
  logic [2:0] irqStat, irqMask, events;
  logic startPend, opPending, ptNeedBrk, dataPhase, sawCr, rxBad;
  logic resultValid, commFail, rxCharPar;
  logic [6:0] opChar, rxChar;
  logic [1:0] byteIdx;
  logic [31:0] waitCnt;
  logic [9:0] secLeft;
  logic [6:0] respMem [16];
  logic txReady, rxValid, rxParErr, lineOe;
  logic [6:0] rxData;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire wrFire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  wire wrCtrl = wrFire && s_axi_awaddr == srl_pkg::ADDR_CTRL;
  wire wrMask = wrFire && s_axi_awaddr == srl_pkg::ADDR_IRQ_MASK && s_axi_wstrb[0];
  wire wrOp = wrFire && s_axi_awaddr == srl_pkg::ADDR_OP_TX && s_axi_wstrb[0];
  wire wrCfg = wrFire && s_axi_awaddr == srl_pkg::ADDR_PORTCFG && s_axi_wstrb[0];
  wire wrMapped = (s_axi_awaddr <= srl_pkg::ADDR_PORTCFG) && (s_axi_awaddr[1:0] == 2'b00);
  wire rdFire = s_axi_arvalid && !s_axi_rvalid;
  wire rdIrq = rdFire && s_axi_araddr == srl_pkg::ADDR_IRQ_STAT;
  wire rdResp = s_axi_araddr >= srl_pkg::ADDR_RESP_BASE && s_axi_araddr <= srl_pkg::ADDR_RESP_LAST;
  wire rdMapped = (s_axi_araddr <= srl_pkg::ADDR_PORTCFG || rdResp) && s_axi_araddr[1:0] == 2'b00;
  wire [3:0] rdSlot = 4'((s_axi_araddr - srl_pkg::ADDR_RESP_BASE) >> 2);
  wire busy = (state != SQ_IDLE);
  wire [31:0] statusWord = {srl_pkg::PROTO_REV, 16'h0000, respIdx,
                            opPending, commFail, resultValid, busy}; // [RULE2]
  wire [31:0] ctrlWord = {12'h000, ctrlMaxRetry, 1'b0, ctrlAddr, 5'h00, ctrlQuery, ctrlPass,
                          1'b0};
  wire [31:0] rdWord =
    (s_axi_araddr == srl_pkg::ADDR_CTRL) ? ctrlWord :
    (s_axi_araddr == srl_pkg::ADDR_STATUS) ? statusWord :
    (s_axi_araddr == srl_pkg::ADDR_IRQ_STAT) ? {29'h0, irqStat} :
    (s_axi_araddr == srl_pkg::ADDR_IRQ_MASK) ? {29'h0, irqMask} :
    (s_axi_araddr == srl_pkg::ADDR_OP_TX) ? {25'h0, opChar} :
    (s_axi_araddr == srl_pkg::ADDR_OP_RX) ? {23'h0, rxCharPar, 1'b0, rxChar} :
    (s_axi_araddr == srl_pkg::ADDR_PORTCFG) ? {30'h0, linkOnTwo, linkEnable} :
    (rdMapped) ? {25'h0, respMem[rdSlot]} : 32'h0;

  assign s_axi_awready = s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_wready = s_axi_awvalid && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign irq = |(irqStat & irqMask);
  assign controlTerminalOneCountFree = !(linkEnable && linkOnTwo); // [RULE12]
  assign controlTerminalTwoCountFree = !(linkEnable && !linkOnTwo); // [RULE12]
  assign sdiOe = lineOe && linkEnable;

  // ----------------------------------------------------------------
  // Serial engine hookup
  // ----------------------------------------------------------------
  wire opGo = (state == SQ_IDLE) && opPending && ctrlPass && !startPend && txReady;
  wire seqTx = (state == SQ_SEND);
  wire [1:0] lastIdx = ctrlQuery ? 2'd1 : (dataPhase ? 2'd3 : 2'd2);
  wire [6:0] txData = seqTx ? srl_cmd_char(ctrlQuery, dataPhase, ctrlAddr, byteIdx) : opChar;
  wire txValid = seqTx || (opGo && !ptNeedBrk); // [RULE11]
  wire brkReq = (state == SQ_BREAK && txReady) || (opGo && ptNeedBrk);
  wire lineEnd = rxValid && rxData == srl_pkg::CH_LF && sawCr; // [RULE8]
  wire addrMatch = ctrlQuery ? srl_addr_ok(respMem[0]) : (respMem[0] == ctrlAddr);
  wire respOk = !rxBad && !rxParErr && addrMatch && respIdx != 4'd0;
  wire timeout = (state == SQ_WAIT) && waitCnt == 32'(RESP_CYCLES - 1);
  wire retryNow = timeout || (state == SQ_WAIT && lineEnd && !respOk); // [RULE10]
  wire [9:0] measSecs = srl_digit(respMem[1]) * 10'd100 + srl_digit(respMem[2]) * 10'd10 +
                        srl_digit(respMem[3]);

  srl_serial #(
    .BIT_CYCLES(BIT_CYCLES),
    .BREAK_CYCLES(BREAK_CYCLES),
    .MARK_CYCLES(MARK_CYCLES)
  ) u_serial (
    .sys_clk(sys_clk),
    .rst(rst),
    .txValid(txValid),
    .txData(txData),
    .txReady(txReady),
    .brkReq(brkReq),
    .rxValid(rxValid),
    .rxData(rxData),
    .rxParErr(rxParErr),
    .lineIn(sdiIn),
    .lineOut(sdiOut),
    .lineOe(lineOe)
  );

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= srl_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= srl_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h0;
      irqStat <= 3'h0;
      irqMask <= 3'h0;
    end else begin
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? srl_pkg::RESP_OKAY : srl_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rdFire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdWord;
        s_axi_rresp <= rdMapped ? srl_pkg::RESP_OKAY : srl_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      // A read clears what it returned; a same-cycle event still sets.
      irqStat <= (irqStat & ~(rdIrq ? irqStat : 3'h0)) | events;
      if (wrMask) begin
        irqMask <= s_axi_wdata[2:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrlPass <= 1'b0;
      ctrlQuery <= 1'b0;
      ctrlAddr <= srl_pkg::RST_ADDR;
      ctrlMaxRetry <= srl_pkg::RST_RETRY;
      {linkOnTwo, linkEnable} <= srl_pkg::RST_PORTCFG;
    end else begin
      if (wrCtrl && s_axi_wstrb[0]) begin
        ctrlPass <= s_axi_wdata[srl_pkg::CTRL_PASS];
        ctrlQuery <= s_axi_wdata[srl_pkg::CTRL_QUERY];
      end
      if (wrCtrl && s_axi_wstrb[1]) begin
        ctrlAddr <= s_axi_wdata[srl_pkg::CTRL_ADDR_LSB +: 7];
      end
      if (wrCtrl && s_axi_wstrb[2]) begin
        ctrlMaxRetry <= s_axi_wdata[srl_pkg::CTRL_RETRY_LSB +: 4];
      end
      if (wrCfg) begin
        linkEnable <= s_axi_wdata[srl_pkg::CFG_ENABLE];
        linkOnTwo <= s_axi_wdata[srl_pkg::CFG_ON_TWO];
      end
    end
  end

  // ----------------------------------------------------------------
  // Received characters and response capture
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rxValid && respIdx != 4'hf) begin
      respMem[respIdx] <= rxData;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rxChar <= 7'h00;
      rxCharPar <= 1'b0;
    end else if (rxValid) begin
      rxChar <= rxData;
      rxCharPar <= rxParErr;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= SQ_IDLE;
      startPend <= 1'b0;
      opPending <= 1'b0;
      opChar <= 7'h00;
      ptNeedBrk <= 1'b1;
      dataPhase <= 1'b0;
      retryCnt <= 4'd0;
      byteIdx <= 2'd0;
      waitCnt <= 32'd0;
      secLeft <= 10'd0;
      respIdx <= 4'd0;
      sawCr <= 1'b0;
      rxBad <= 1'b0;
      resultValid <= 1'b0;
      commFail <= 1'b0;
      events <= 3'h0;
    end else begin
      events <= {rxValid, 2'b00};
      if (wrCtrl && s_axi_wstrb[0] && s_axi_wdata[srl_pkg::CTRL_START]) begin
        startPend <= 1'b1;
      end
      if (wrOp && !opPending) begin
        opPending <= 1'b1;
        opChar <= s_axi_wdata[6:0];
      end
      if (opGo && ptNeedBrk) begin
        ptNeedBrk <= 1'b0;
      end else if (opGo) begin
        opPending <= 1'b0;
        ptNeedBrk <= (opChar == srl_pkg::CH_EXCL);
      end
      if (rxValid) begin
        respIdx <= (respIdx == 4'hf) ? respIdx : respIdx + 4'd1;
        sawCr <= (rxData == srl_pkg::CH_CR);
        rxBad <= rxBad | rxParErr;
      end
      case (state)
        SQ_IDLE: begin
          if (startPend && txReady) begin
            startPend <= 1'b0;
            if (linkEnable && (ctrlQuery || srl_addr_ok(ctrlAddr))) begin // [RULE4]
              state <= SQ_BREAK;
              dataPhase <= 1'b0;
              retryCnt <= 4'd0;
              resultValid <= 1'b0;
              commFail <= 1'b0;
            end else begin
              commFail <= 1'b1;
              events[srl_pkg::IRQ_FAIL] <= 1'b1;
            end
          end
        end
        SQ_BREAK: begin
          if (txReady) begin
            state <= SQ_SEND;
            byteIdx <= 2'd0;
          end
        end
        SQ_SEND: begin
          if (txReady) begin
            byteIdx <= byteIdx + 2'd1;
            if (byteIdx == lastIdx) begin
              state <= SQ_WAIT;
              waitCnt <= 32'd0;
              respIdx <= 4'd0;
              sawCr <= 1'b0;
              rxBad <= 1'b0;
            end
          end
        end
        SQ_WAIT: begin
          // Every character restarts the wait, so long answers are not cut short.
          waitCnt <= rxValid ? 32'd0 : waitCnt + 32'd1;
          if (retryNow) begin
            if (retryCnt == ctrlMaxRetry) begin
              state <= SQ_IDLE;
              commFail <= 1'b1; // [RULE13]
              resultValid <= 1'b0; // [RULE13]
              events[srl_pkg::IRQ_FAIL] <= 1'b1;
            end else begin
              retryCnt <= retryCnt + 4'd1; // [RULE10]
              state <= SQ_BREAK;
            end
          end else if (lineEnd && (ctrlQuery || dataPhase)) begin
            state <= SQ_IDLE;
            resultValid <= 1'b1;
            events[srl_pkg::IRQ_DONE] <= 1'b1;
          end else if (lineEnd) begin
            state <= SQ_MEAS;
            secLeft <= measSecs; // [RULE9]
            waitCnt <= 32'd0;
          end
        end
        default: begin
          if (secLeft == 10'd0) begin
            state <= SQ_BREAK; // [RULE9]
            dataPhase <= 1'b1;
            retryCnt <= 4'd0;
          end else if (waitCnt == 32'(SEC_CYCLES - 1)) begin
            waitCnt <= 32'd0;
            secLeft <= secLeft - 10'd1;
          end else begin
            waitCnt <= waitCnt + 32'd1;
          end
        end
      endcase
    end
  end
endmodule : srl_recorder_link
`default_nettype wire

// File: srl_recorder_link_chk.sv
// Port-level assertions for the recorder link.
`default_nettype none
module srl_recorder_link_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Wire and terminals
  input wire logic sdiOut,
  input wire logic sdiOe,
  input wire logic controlTerminalOneCountFree,
  input wire logic controlTerminalTwoCountFree
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_BTAKE: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("write not answered");
  AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  AST_RTAKE: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("read not answered");
  AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  AST_ARDY: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready wrong");
  AST_AWRDY: assert property (s_axi_awready == (s_axi_wvalid && !s_axi_bvalid))
    else $error("awready wrong");
  AST_RST: assert property ($past(rst) |-> !s_axi_bvalid && !s_axi_rvalid && !sdiOe)
    else $error("not idle after reset");
  AST_LOWBIT: assert property (sdiOe && $fell(sdiOut) |-> !sdiOut [*8])
    else $error("low bit too short");
  AST_HIGHBIT: assert property (sdiOe && $rose(sdiOut) |-> sdiOut [*8])
    else $error("high bit too short");
  AST_TERM: assert property (controlTerminalOneCountFree || controlTerminalTwoCountFree)
    else $error("both terminals taken");
endmodule : srl_recorder_link_chk
bind srl_recorder_link srl_recorder_link_chk u_chk (.sys_clk, .rst, .s_axi_awvalid,
  .s_axi_wvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .sdiOut, .sdiOe,
  .controlTerminalOneCountFree, .controlTerminalTwoCountFree);
`default_nettype wire

// File: srl_sensor_model.sv
// Behavioural sensor at address 0 on the data wire.
`default_nettype none
module srl_sensor_model #(parameter int BIT = 16) (
  input wire logic sys_clk,
  input wire logic line,
  input wire logic mute,
  output logic mdlOut,
  output logic mdlOe
);
  logic [6:0] got[$];
  logic [7:0] ch;
  string s;
  task automatic tx(input logic [6:0] c);
    logic [9:0] f;
    f = {1'b1, ^c, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      mdlOut <= f[i];
      mdlOe <= 1'b1;
      repeat (BIT) @(posedge sys_clk);
    end
  endtask : tx
  initial begin
    mdlOut = 1'b1;
    mdlOe = 1'b0;
    forever begin
      // A frame whose stop sample is low is a break and is discarded.
      @(negedge line);
      repeat (BIT * 3 / 2) @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
        ch[i] = line;
        repeat (BIT) @(posedge sys_clk);
      end
      if (line) got.push_back(ch[6:0]);
      wait (line);
      if (ch[6:0] == 7'h21 && !mute) begin
        repeat (BIT * 2) @(posedge sys_clk);
        s = (got[got.size() - 2] == 7'h4d) ? "0001\r\n" : "0+1\r\n";
        foreach (s[i]) tx(s[i][6:0]);
        mdlOe <= 1'b0;
      end
    end
  end
endmodule : srl_sensor_model
`default_nettype wire

// File: srl_serial.sv
// Half-duplex 7E1 serial engine with break, for the data wire.
`default_nettype none
module srl_serial #(
  parameter int BIT_CYCLES = srl_pkg::BIT_CYCLES,
  parameter int BREAK_CYCLES = srl_pkg::BREAK_CYCLES,
  parameter int MARK_CYCLES = srl_pkg::MARK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Transmit side
  input wire logic txValid,
  input wire logic [6:0] txData,
  output logic txReady,
  input wire logic brkReq,
  // Receive side
  output logic rxValid,
  output logic [6:0] rxData,
  output logic rxParErr,
  // Data wire
  input wire logic lineIn,
  output logic lineOut,
  output logic lineOe
);
  typedef enum logic [1:0] {T_IDLE, T_BRK, T_MARK, T_SHIFT} srl_tx_e;
  srl_tx_e tState;
  logic [31:0] tCnt;
  logic [3:0] tBits;
  logic [9:0] tSh;
  logic s1, s2, s3, rxLvl, rBusy;
  logic [31:0] rCnt;
  logic [3:0] rBit;
  logic [7:0] rSh;
  wire tTick = (tCnt == 32'd0);
  wire rTick = (rCnt == 32'd0);

  assign txReady = (tState == T_IDLE);
  assign lineOe = (tState != T_IDLE);
  assign lineOut = (tState == T_SHIFT) ? tSh[0] : (tState != T_BRK);

  // ----------------------------------------------------------------
  // Transmitter: break, marking, then start, 7 data, even parity, stop
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tState <= T_IDLE;
      tCnt <= 32'd0;
      tBits <= 4'd0;
      tSh <= 10'h3ff;
    end else begin
      tCnt <= tTick ? 32'd0 : tCnt - 32'd1;
      case (tState)
        T_IDLE: begin
          if (brkReq) begin
            tState <= T_BRK;
            tCnt <= 32'(BREAK_CYCLES - 1);
          end else if (txValid) begin
            tState <= T_SHIFT;
            tSh <= {1'b1, ^txData, txData, 1'b0}; // [RULE1]
            tBits <= 4'd9;
            tCnt <= 32'(BIT_CYCLES - 1);
          end
        end
        T_BRK: begin
          if (tTick) begin
            tState <= T_MARK;
            tCnt <= 32'(MARK_CYCLES - 1);
          end
        end
        T_MARK: begin
          if (tTick) begin
            tState <= T_IDLE;
          end
        end
        default: begin
          if (tTick) begin
            tSh <= {1'b1, tSh[9:1]};
            tCnt <= 32'(BIT_CYCLES - 1);
            tBits <= tBits - 4'd1;
            if (tBits == 4'd0) begin
              tState <= T_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receiver: the wire level changes only when the last two stages agree
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      rxLvl <= 1'b1;
    end else begin
      s1 <= lineIn;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        rxLvl <= s3;
      end
    end
  end

  // Our own transmission is not received back, which keeps the link half duplex.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rBusy <= 1'b0;
      rCnt <= 32'd0;
      rBit <= 4'd0;
      rSh <= 8'h00;
      rxValid <= 1'b0;
      rxData <= 7'h00;
      rxParErr <= 1'b0;
    end else begin
      rxValid <= 1'b0;
      rCnt <= rTick ? 32'd0 : rCnt - 32'd1;
      if (!rBusy) begin
        if (!rxLvl && !lineOe) begin
          rBusy <= 1'b1;
          rBit <= 4'd0;
          rCnt <= 32'(BIT_CYCLES / 2);
        end
      end else if (rTick) begin
        rCnt <= 32'(BIT_CYCLES - 1);
        rBit <= rBit + 4'd1;
        if (rBit == 4'd0 && rxLvl) begin
          rBusy <= 1'b0;
        end else if (rBit == 4'd9) begin
          rBusy <= 1'b0;
          rxValid <= 1'b1;
          rxData <= rSh[6:0];
          rxParErr <= (^rSh) | ~rxLvl; // [RULE1]
        end else if (rBit != 4'd0) begin
          rSh <= {rxLvl, rSh[7:1]};
        end
      end
    end
  end
endmodule : srl_serial
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the recorder link.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, mute = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd;
  logic [3:0] ws = 0;
  wire logic awr, wr_, bv, arr, rv, sOut, sOe, mOut, mOe, irq, ctOne, ctTwo;
  wire logic [1:0] br, rr;
  wire logic [31:0] rdt;
  // Released wire idles at marking via the pull-up.
  wire logic line = sOe ? sOut : (mOe ? mOut : 1'b1);
  int miscompares = 0, checksDone = 0;
  always #10 sys_clk = ~sys_clk;
  srl_recorder_link #(.BIT_CYCLES(16), .BREAK_CYCLES(200), .MARK_CYCLES(30),
    .RESP_CYCLES(400), .SEC_CYCLES(100)) u_srl_recorder_link (.sys_clk, .rst,
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .sdiIn(line), .sdiOut(sOut), .sdiOe(sOe), .irq,
    .controlTerminalOneCountFree(ctOne), .controlTerminalTwoCountFree(ctTwo));
  srl_sensor_model u_srl_sensor_model (.sys_clk, .line,
    .mute, .mdlOut(mOut), .mdlOe(mOe));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checksDone++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    awa <= a; wd <= d; ws <= 4'hf; awv <= 1; wv <= 1; bry <= 1;
    do @(posedge sys_clk); while (awr !== 1'b1);
    awv <= 0; wv <= 0;
    do @(posedge sys_clk); while (bv !== 1'b1);
  endtask : wrr
  task automatic rdr(input logic [7:0] a);
    ara <= a; arv <= 1; rry <= 1;
    do @(posedge sys_clk); while (arr !== 1'b1);
    arv <= 0;
    do @(posedge sys_clk); while (rv !== 1'b1);
    rd = rdt;
    chk("rresp", {30'h0, rr}, (a == 8'h1c) ? 32'h2 : 32'h0);
  endtask : rdr
  task automatic wirq();
    for (int n = 0; n < 20000 && irq !== 1'b1; n++) @(posedge sys_clk);
    chk("irq", {31'h0, irq}, 32'h1);
  endtask : wirq
  task automatic cmds(input string e);
    chk("cmd count", u_srl_sensor_model.got.size(), e.len());
    foreach (e[i]) chk("cmd char", {25'h0, u_srl_sensor_model.got[i]}, {24'h0, e[i]});
    u_srl_sensor_model.got.delete();
  endtask : cmds
  task automatic t_reset();
    rdr(srl_pkg::ADDR_STATUS);
    chk("revision", rd[31:24], 8'h14);
    rdr(srl_pkg::ADDR_CTRL);
    chk("ctrl", rd, 32'h0003_3000);
    rdr(8'h1c);
    chk("terminals", {ctOne, ctTwo}, 2'b10);
    $display("reset done");
  endtask : t_reset
  task automatic t_badaddr();
    wrr(srl_pkg::ADDR_CTRL, 32'h0003_2301);
    repeat (400) @(posedge sys_clk);
    rdr(srl_pkg::ADDR_STATUS);
    chk("commFail", rd[2], 1'b1);
    cmds("");
    $display("bad address done");
  endtask : t_badaddr
  task automatic t_measure();
    rdr(srl_pkg::ADDR_IRQ_STAT);
    wrr(srl_pkg::ADDR_IRQ_MASK, 32'h1);
    wrr(srl_pkg::ADDR_CTRL, 32'h0003_3001);
    wirq();
    cmds("0M!0D0!");
    rdr(srl_pkg::ADDR_STATUS);
    chk("result valid", rd[1], 1'b1);
    rdr(srl_pkg::ADDR_RESP_BASE + 8'h4);
    chk("resp char", rd[6:0], 7'h2b);
    rdr(srl_pkg::ADDR_IRQ_STAT);
    chk("done", rd[0], 1'b1);
    rdr(srl_pkg::ADDR_IRQ_STAT);
    chk("done cleared", rd[0], 1'b0);
    $display("measure done");
  endtask : t_measure
  task automatic t_retry();
    mute <= 1;
    wrr(srl_pkg::ADDR_IRQ_MASK, 32'h2);
    wrr(srl_pkg::ADDR_CTRL, 32'h0001_3001);
    wirq();
    cmds("0M!0M!");
    rdr(srl_pkg::ADDR_STATUS);
    chk("fail flags", rd[2:1], 2'b10);
    wrr(srl_pkg::ADDR_PORTCFG, 32'h3);
    chk("terminals", {ctOne, ctTwo}, 2'b01);
    $display("retry done");
  endtask : t_retry
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 0;
    t_reset();
    t_badaddr();
    t_measure();
    t_retry();
    end_sim();
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    miscompares++;
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
